/* File: hw/dls_diag_live_status_regs.sv */
`timescale 1ns/10ps
`include "dls_map.svh"

// Operation
// - the summary register at 0x3D is read-only and resets to all zeros.
// - summary bit 7 is one while input channel 1 has any fault.
// - summary bit 6 is one while input channel 2 has any fault.
// - summary bit 5 is one while output channel 1 has any fault.
// - summary bit 4 is one while output channel 2 has any fault.
// - summary bit 3 is one while a battery short with battery below bias is seen on any channel.
// - summary bits 2 to 0 read zero and software writes only zero there.
// - input 1 register at 0x3E shows open inputs in bit 7 and inputs shorted together in bit 6.
// - input 1 bits 5 and 4 show positive and negative input shorted to ground.
// - input 1 bits 3 and 2 show positive and negative input shorted to the bias.
// - input 1 bits 1 and 0 show positive and negative input shorted to the battery.
// - input 2 register at 0x3F shows open inputs in bit 7, shorted inputs in bit 6, reset zero.
// - input 2 bits 5 and 4 show positive and negative input shorted to ground.
// - input 2 bits 3 and 2 show positive and negative input shorted to the bias.
// - input 2 bits 1 and 0 show positive and negative input shorted to the battery.
module dls_diag_live_status_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register read port
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // input channel 1 detectors
  input wire logic in1Open,
  input wire logic in1Shorted,
  input wire logic in1PosGnd,
  input wire logic in1NegGnd,
  input wire logic in1PosBias,
  input wire logic in1NegBias,
  input wire logic in1PosBat,
  input wire logic in1NegBat,
  // input channel 2 detectors
  input wire logic in2Open,
  input wire logic in2Shorted,
  input wire logic in2PosGnd,
  input wire logic in2NegGnd,
  input wire logic in2PosBias,
  input wire logic in2NegBias,
  input wire logic in2PosBat,
  input wire logic in2NegBat,
  // output channels and battery
  input wire logic out1Fault,
  input wire logic out2Fault,
  input wire logic batShortLow
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstMeta;
  logic rstN;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // ----------------------------------------
  // detector synchronisers
  // ----------------------------------------
  // detectors are analog and asynchronous; two flops per bit, no filtering
  logic [`DLS_DET_WIDTH-1:0] rawDet;
  logic [`DLS_DET_WIDTH-1:0] detMeta;
  logic [`DLS_DET_WIDTH-1:0] detLive;

  assign rawDet = {in1Open, in1Shorted, in1PosGnd, in1NegGnd, in1PosBias, in1NegBias, in1PosBat, in1NegBat,
                   in2Open, in2Shorted, in2PosGnd, in2NegGnd, in2PosBias, in2NegBias, in2PosBat, in2NegBat,
                   out1Fault, out2Fault, batShortLow};

  genvar gi;
  generate
    for (gi = 0; gi < `DLS_DET_WIDTH; gi = gi + 1) begin : g_sync
      always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
          detMeta[gi] <= 1'b0;
          detLive[gi] <= 1'b0;
        end else begin
          detMeta[gi] <= rawDet[gi];
          detLive[gi] <= detMeta[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // register images
  // ----------------------------------------
  dls_pkg::dls_byte_t in1Live;
  dls_pkg::dls_byte_t in2Live;
  dls_pkg::dls_byte_t summary;

  // live images are pure wiring of the synchronised detectors, nothing latches
  assign in1Live = detLive[18:11];
  assign in2Live = detLive[10:3];

  always_comb begin
    summary = `DLS_RST_SUMMARY;
    summary[`DLS_SUM_IN1] = |in1Live;
    summary[`DLS_SUM_IN2] = |in2Live;
    summary[`DLS_SUM_OUT1] = detLive[2];
    summary[`DLS_SUM_OUT2] = detLive[1];
    summary[`DLS_SUM_BATLOW] = detLive[0];
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  dls_pkg::dls_sel_t sel;
  dls_pkg::dls_byte_t next_rdData;

  always_comb begin
    unique case (regAddr)
      `DLS_OFS_SUMMARY: sel = dls_pkg::SEL_SUM;
      `DLS_OFS_IN1: sel = dls_pkg::SEL_IN1;
      `DLS_OFS_IN2: sel = dls_pkg::SEL_IN2;
      default: sel = dls_pkg::SEL_NONE;
    endcase
  end

  always_comb begin
    unique case (sel)
      dls_pkg::SEL_SUM: next_rdData = summary;
      dls_pkg::SEL_IN1: next_rdData = in1Live;
      dls_pkg::SEL_IN2: next_rdData = in2Live;
      dls_pkg::SEL_NONE: next_rdData = `DLS_UNMAPPED_DATA;
      default: next_rdData = `DLS_UNMAPPED_DATA;
    endcase
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // a read only samples; no flag here is cleared by it
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= `DLS_RST_RDDATA;
    end else if (regRd) begin
      regRdData <= next_rdData;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_sum_read;
    @(posedge core_clk) disable iff (!rstN)
    regRd && regAddr == `DLS_OFS_SUMMARY |=> regRdValid && regRdData == $past(summary);
  endproperty
  a_sum_read: assert property (p_sum_read) else $error("summary read data wrong");

  property p_in1_any;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> summary[`DLS_SUM_IN1] == (|$past(rawDet[18:11], 2));
  endproperty
  a_in1_any: assert property (p_in1_any) else $error("input 1 summary not OR of faults");

  property p_in2_any;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> summary[`DLS_SUM_IN2] == (|$past(rawDet[10:3], 2));
  endproperty
  a_in2_any: assert property (p_in2_any) else $error("input 2 summary not OR of faults");

  property p_out1;
    @(posedge core_clk) disable iff (!rstN)
    $rose(out1Fault) ##1 out1Fault |=> summary[`DLS_SUM_OUT1];
  endproperty
  a_out1: assert property (p_out1) else $error("output 1 fault not in summary");

  property p_out2;
    @(posedge core_clk) disable iff (!rstN)
    $fell(out2Fault) ##1 !out2Fault |=> !summary[`DLS_SUM_OUT2];
  endproperty
  a_out2: assert property (p_out2) else $error("output 2 summary not cleared");

  property p_batlow;
    @(posedge core_clk) disable iff (!rstN)
    regRd && regAddr == `DLS_OFS_SUMMARY |=> regRdData[`DLS_SUM_BATLOW] == $past(batShortLow, 3);
  endproperty
  a_batlow: assert property (p_batlow) else $error("battery short summary wrong");

  property p_rsvd;
    @(posedge core_clk) disable iff (!rstN)
    regRd && regAddr == `DLS_OFS_SUMMARY |=> regRdData[`DLS_SUM_RSVD_HI:`DLS_SUM_RSVD_LO] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved summary bits not zero");

  property p_in1_map;
    @(posedge core_clk) disable iff (!rstN)
    regRd && regAddr == `DLS_OFS_IN1 |=>
      regRdData[`DLS_IN_OPEN] == $past(in1Open, 3) && regRdData[`DLS_IN_SHORTED] == $past(in1Shorted, 3) &&
      regRdData[`DLS_IN_POS_GND] == $past(in1PosGnd, 3) && regRdData[`DLS_IN_NEG_GND] == $past(in1NegGnd, 3) &&
      regRdData[`DLS_IN_POS_BIAS] == $past(in1PosBias, 3) && regRdData[`DLS_IN_NEG_BIAS] == $past(in1NegBias, 3) &&
      regRdData[`DLS_IN_POS_BAT] == $past(in1PosBat, 3) && regRdData[`DLS_IN_NEG_BAT] == $past(in1NegBat, 3);
  endproperty
  a_in1_map: assert property (p_in1_map) else $error("input 1 field map wrong");

  property p_in2_map;
    @(posedge core_clk) disable iff (!rstN)
    regRd && regAddr == `DLS_OFS_IN2 |=>
      regRdData[`DLS_IN_OPEN] == $past(in2Open, 3) && regRdData[`DLS_IN_SHORTED] == $past(in2Shorted, 3) &&
      regRdData[`DLS_IN_POS_GND] == $past(in2PosGnd, 3) && regRdData[`DLS_IN_NEG_GND] == $past(in2NegGnd, 3) &&
      regRdData[`DLS_IN_POS_BIAS] == $past(in2PosBias, 3) && regRdData[`DLS_IN_NEG_BIAS] == $past(in2NegBias, 3) &&
      regRdData[`DLS_IN_POS_BAT] == $past(in2PosBat, 3) && regRdData[`DLS_IN_NEG_BAT] == $past(in2NegBat, 3);
  endproperty
  a_in2_map: assert property (p_in2_map) else $error("input 2 field map wrong");

  property p_hold;
    @(posedge core_clk) disable iff (!rstN)
    !regRd |=> $stable(regRdData) && !regRdValid;
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");

  property p_unmapped;
    @(posedge core_clk) disable iff (!rstN)
    regRd && sel == dls_pkg::SEL_NONE |=> regRdData == `DLS_UNMAPPED_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_reset_regs;
    @(posedge core_clk)
    !rstN |-> regRdData == `DLS_RST_RDDATA && !regRdValid;
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("read port not cleared in reset");

  property p_read_valid;
    @(posedge core_clk) disable iff (!rstN)
    regRd |=> regRdValid;
  endproperty
  a_read_valid: assert property (p_read_valid) else $error("read not answered after one cycle");

  property p_out1_clear;
    @(posedge core_clk) disable iff (!rstN)
    $fell(out1Fault) ##1 !out1Fault |=> !summary[`DLS_SUM_OUT1];
  endproperty
  a_out1_clear: assert property (p_out1_clear) else $error("output 1 summary not cleared");

  property p_out2_set;
    @(posedge core_clk) disable iff (!rstN)
    $rose(out2Fault) ##1 out2Fault |=> summary[`DLS_SUM_OUT2];
  endproperty
  a_out2_set: assert property (p_out2_set) else $error("output 2 fault not in summary");

  property p_batlow_set;
    @(posedge core_clk) disable iff (!rstN)
    $rose(batShortLow) ##1 batShortLow |=> summary[`DLS_SUM_BATLOW];
  endproperty
  a_batlow_set: assert property (p_batlow_set) else $error("battery short not in summary");

  property p_batlow_clear;
    @(posedge core_clk) disable iff (!rstN)
    $fell(batShortLow) ##1 !batShortLow |=> !summary[`DLS_SUM_BATLOW];
  endproperty
  a_batlow_clear: assert property (p_batlow_clear) else $error("battery short summary not cleared");

  property p_in1_gnd;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> in1Live[`DLS_IN_POS_GND] == $past(in1PosGnd, 2) &&
      in1Live[`DLS_IN_NEG_GND] == $past(in1NegGnd, 2);
  endproperty
  a_in1_gnd: assert property (p_in1_gnd) else $error("input 1 ground short bits wrong");

  property p_in1_bias;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> in1Live[`DLS_IN_POS_BIAS] == $past(in1PosBias, 2) &&
      in1Live[`DLS_IN_NEG_BIAS] == $past(in1NegBias, 2);
  endproperty
  a_in1_bias: assert property (p_in1_bias) else $error("input 1 bias short bits wrong");

  property p_in1_bat;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> in1Live[`DLS_IN_POS_BAT] == $past(in1PosBat, 2) &&
      in1Live[`DLS_IN_NEG_BAT] == $past(in1NegBat, 2);
  endproperty
  a_in1_bat: assert property (p_in1_bat) else $error("input 1 battery short bits wrong");

  property p_in2_gnd;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> in2Live[`DLS_IN_POS_GND] == $past(in2PosGnd, 2) &&
      in2Live[`DLS_IN_NEG_GND] == $past(in2NegGnd, 2);
  endproperty
  a_in2_gnd: assert property (p_in2_gnd) else $error("input 2 ground short bits wrong");

  property p_in2_bias;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> in2Live[`DLS_IN_POS_BIAS] == $past(in2PosBias, 2) &&
      in2Live[`DLS_IN_NEG_BIAS] == $past(in2NegBias, 2);
  endproperty
  a_in2_bias: assert property (p_in2_bias) else $error("input 2 bias short bits wrong");

  property p_in2_bat;
    @(posedge core_clk) disable iff (!rstN)
    $past(rstN, 2) |-> in2Live[`DLS_IN_POS_BAT] == $past(in2PosBat, 2) &&
      in2Live[`DLS_IN_NEG_BAT] == $past(in2NegBat, 2);
  endproperty
  a_in2_bat: assert property (p_in2_bat) else $error("input 2 battery short bits wrong");

endmodule

/* File: hw/dls_map.svh */
`ifndef DLS_MAP_SVH
`define DLS_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DLS_OFS_SUMMARY 8'h3d
`define DLS_OFS_IN1 8'h3e
`define DLS_OFS_IN2 8'h3f

// ----------------------------------------
// reset values
// ----------------------------------------
`define DLS_RST_SUMMARY 8'h00
`define DLS_RST_IN1 8'h00
`define DLS_RST_IN2 8'h00
`define DLS_RST_RDDATA 8'h00
`define DLS_UNMAPPED_DATA 8'h00

// ----------------------------------------
// summary field positions
// ----------------------------------------
`define DLS_SUM_IN1 7
`define DLS_SUM_IN2 6
`define DLS_SUM_OUT1 5
`define DLS_SUM_OUT2 4
`define DLS_SUM_BATLOW 3
`define DLS_SUM_RSVD_HI 2
`define DLS_SUM_RSVD_LO 0

// ----------------------------------------
// input channel detail field positions
// ----------------------------------------
`define DLS_IN_OPEN 7
`define DLS_IN_SHORTED 6
`define DLS_IN_POS_GND 5
`define DLS_IN_NEG_GND 4
`define DLS_IN_POS_BIAS 3
`define DLS_IN_NEG_BIAS 2
`define DLS_IN_POS_BAT 1
`define DLS_IN_NEG_BAT 0

// ----------------------------------------
// detector synchroniser
// ----------------------------------------
`define DLS_DET_WIDTH 19
`define DLS_SYNC_LATENCY 2

`endif

/* File: hw/dls_pkg.sv */
package dls_pkg;

  typedef logic [7:0] dls_byte_t;

  // one-hot register select
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_SUM  = 4'b0010,
    SEL_IN1  = 4'b0100,
    SEL_IN2  = 4'b1000
  } dls_sel_t;

endpackage

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
  logic core_clk;
  logic nrst;
  logic regRd;
  logic [7:0] regAddr;
  logic [7:0] regRdData;
  logic regRdValid;
  logic [7:0] in1Det;
  logic [7:0] in2Det;
  logic out1Fault;
  logic out2Fault;
  logic batShortLow;
  int miscompares;
  int comparisons;
  int cycleCount;
  logic [7:0] rdData;
  logic rdValid;

  dls_diag_live_status_regs i_dut (
    .core_clk(core_clk), .nrst(nrst), .regRd(regRd), .regAddr(regAddr),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .in1Open(in1Det[7]), .in1Shorted(in1Det[6]), .in1PosGnd(in1Det[5]), .in1NegGnd(in1Det[4]),
    .in1PosBias(in1Det[3]), .in1NegBias(in1Det[2]), .in1PosBat(in1Det[1]), .in1NegBat(in1Det[0]),
    .in2Open(in2Det[7]), .in2Shorted(in2Det[6]), .in2PosGnd(in2Det[5]), .in2NegGnd(in2Det[4]),
    .in2PosBias(in2Det[3]), .in2NegBias(in2Det[2]), .in2PosBat(in2Det[1]), .in2NegBat(in2Det[0]),
    .out1Fault(out1Fault), .out2Fault(out2Fault), .batShortLow(batShortLow)
  );

  // ----------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ceiling well above the few hundred cycles the scenarios take
  always @(posedge core_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // single read: request stands for one taken edge, answer looked at while valid stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
    v = regRdValid;
  endtask

  // detectors pass two synchroniser flops before the image
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_and_unmapped;
    rd(8'h3d, rdData, rdValid);
    check("summary reset", rdData, 8'h00);
    check("read valid", {7'h00, rdValid}, 8'h01);
    rd(8'h3e, rdData, rdValid);
    check("in1 reset", rdData, 8'h00);
    rd(8'h3f, rdData, rdValid);
    check("in2 reset", rdData, 8'h00);
    rd(8'h40, rdData, rdValid);
    check("unmapped", rdData, 8'h00);
    check("unmapped valid", {7'h00, rdValid}, 8'h01);
  endtask

  // walking one over each detector of one input channel
  task automatic t_input_walk(input bit second);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      if (second) in2Det <= 8'h01 << i;
      else in1Det <= 8'h01 << i;
      settle();
      rd(second ? 8'h3f : 8'h3e, rdData, rdValid);
      check("detail image", rdData, 8'h01 << i);
      rd(8'h3d, rdData, rdValid);
      check("input summary", rdData, second ? 8'h40 : 8'h80);
    end
    @(posedge core_clk);
    in1Det <= 8'h00;
    in2Det <= 8'h00;
  endtask

  task automatic t_summary_sources;
    logic [7:0] exp;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      out1Fault <= i[0];
      out2Fault <= i[1];
      batShortLow <= i[2];
      settle();
      exp = {2'b00, i[0], i[1], i[2], 3'b000};
      rd(8'h3d, rdData, rdValid);
      check("summary outputs", rdData, exp);
    end
    @(posedge core_clk);
    in1Det <= 8'hff;
    in2Det <= 8'hff;
    settle();
    rd(8'h3d, rdData, rdValid);
    check("summary all set", rdData, 8'hf8);
  endtask

  // values drop two cycles after the detectors clear, once through the synchroniser; back to back reads of 0x3E, 0x3F, 0x3E each return their own image
  task automatic t_live_back_to_back;
    @(posedge core_clk);
    in1Det <= 8'ha5;
    in2Det <= 8'h00;
    out1Fault <= 1'b0;
    out2Fault <= 1'b0;
    batShortLow <= 1'b0;
    settle();
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= 8'h3e;
    @(posedge core_clk);
    regAddr <= 8'h3f;
    #1;
    check("b2b first", regRdData, 8'ha5);
    check("b2b first valid", {7'h00, regRdValid}, 8'h01);
    @(posedge core_clk);
    regAddr <= 8'h3e;
    #1;
    check("b2b second", regRdData, 8'h00);
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    check("b2b third", regRdData, 8'ha5);
    @(posedge core_clk);
    #1;
    check("valid drops", {7'h00, regRdValid}, 8'h00);
    check("data holds", regRdData, 8'ha5);
    @(posedge core_clk);
    in1Det <= 8'h00;
    settle();
    rd(8'h3e, rdData, rdValid);
    check("cleared in1", rdData, 8'h00);
    rd(8'h3d, rdData, rdValid);
    check("cleared summary", rdData, 8'h00);
  endtask

  // detectors stay active through a reset; the read port must still clear
  task automatic t_mid_reset;
    @(posedge core_clk);
    in1Det <= 8'hff;
    settle();
    rd(8'h3e, rdData, rdValid);
    check("in1 before reset", rdData, 8'hff);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("data in reset", regRdData, 8'h00);
    check("valid in reset", {7'h00, regRdValid}, 8'h00);
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(8'h3d, rdData, rdValid);
    check("summary after reset", rdData, 8'h80);
    @(posedge core_clk);
    in1Det <= 8'h00;
    settle();
  endtask

  initial begin
    nrst = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    in1Det = 8'h00;
    in2Det = 8'h00;
    out1Fault = 1'b0;
    out2Fault = 1'b0;
    batShortLow = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cycleCount = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset_and_unmapped();
    t_input_walk(1'b0);
    t_input_walk(1'b1);
    t_summary_sources();
    t_live_back_to_back();
    t_mid_reset();
    complete_run();
  end
endmodule
